// File: hdl/reset_and_powerup_control.sv
// Reset sequencer: merges supply, watchdog and clear pin sources into one chip reset.
// Assumes supply monitors and watchdog give levels synchronous to CLK_SYS; APB slave.
//
// How it works
// - Six causes kept apart: power-on, watchdog run/sleep, pin run/sleep, brownout.
// - Retained registers get no reset output; they see neither the core nor the register reset.
// - Defined-value reset pulses on power-on, pin, watchdog-run and brownout.
// - Watchdog expiry asleep only wakes the core; no register reset.
// - Timeout and powerdown bits take a per-cause pattern software can read; pin causes keep the timeout bit.
// - Clear pin passes a low-level filter; short pulses are ignored.
// - Reset held until supply good, or above brownout threshold when enabled.
// - Power-on detect re-arms only after supply at ground for 100 us.
// - Watchdog reset never drives the clear pin low.
// - Enable bit 0: pin is a general input; 1: pin is an external reset.
// - Weak pull-up on the shared pin while it acts as external reset.
// - Power-up delay of 64 ms runs only after power-on or brownout.
// - Chip held in reset while the power-up delay counts.
// - Power-up delay bypassed when its disable bit is set.
// - Calibration word at 2009h is read-only here and survives bulk erase.
`timescale 1ns/1ps
`include "rst_seq_defs.svh"

module reset_and_powerup_control
#(
  parameter int PUD_CYCLES    = `PUD_CYCLES,
  parameter int REARM_CYCLES  = `REARM_CYCLES,
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter logic [31:0] CALIB_VALUE = 32'h0000_0000  // Arbitrary factory trim stand-in
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        SUPPLY_GOOD,
  input  wire logic        SUPPLY_AT_GROUND,
  input  wire logic        ABOVE_BROWNOUT_THRESHOLD,
  input  wire logic        BROWNOUT_DETECT_ENABLE,
  input  wire logic        EXTERNAL_CLEAR_PIN_ENABLE,
  input  wire logic        POWER_UP_DELAY_DISABLE,
  input  wire logic        SHARED_INPUT_PIN_IN,
  input  wire logic        WATCHDOG_EXPIRE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CORE_RESET_B,
  output logic             REG_RESET_B,
  output logic             WAKE_UP,
  output logic             SHARED_PIN_PULLUP_EN,
  output logic             SHARED_PIN_OUT,
  output logic             SHARED_PIN_OE,
  output logic             GENERAL_INPUT_VALUE,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Clear pin filter and power-on detector

  logic [15:0] filt_cnt_q;
  logic        pin_low_q;
  logic [15:0] rearm_cnt_q;
  logic        por_armed_q;
  logic        por_active_q;

  // Pin must sit low for FILTER_CYCLES before it counts; glitches restart it
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      filt_cnt_q <= 16'h0000;
      pin_low_q  <= 1'b0;
    end
    else if (!EXTERNAL_CLEAR_PIN_ENABLE || SHARED_INPUT_PIN_IN)
    begin
      filt_cnt_q <= 16'h0000;
      pin_low_q  <= 1'b0;
    end
    else if (filt_cnt_q == 16'(FILTER_CYCLES - 1))
      pin_low_q  <= 1'b1;
    else
      filt_cnt_q <= filt_cnt_q + 16'h0001;
  end

  // Detector fires once on rising supply; a falling supply alone does not re-fire it
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rearm_cnt_q  <= 16'h0000;
      por_armed_q  <= 1'b1;
      por_active_q <= 1'b1;
    end
    else
    begin
      if (!SUPPLY_AT_GROUND)
        rearm_cnt_q <= 16'h0000;
      else if (rearm_cnt_q == 16'(REARM_CYCLES - 1))
        por_armed_q <= 1'b1;
      else
        rearm_cnt_q <= rearm_cnt_q + 16'h0001;
      if (por_armed_q && !SUPPLY_AT_GROUND)
        por_active_q <= 1'b1;
      if (por_active_q && SUPPLY_GOOD)
      begin
        por_active_q <= 1'b0;
        por_armed_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  rst_seq_pkg::seq_state_type state_q;
  rst_seq_pkg::cause_type     cause_q;
  logic [31:0] delay_cnt_q;
  logic        sleep_q;
  logic        timeout_q;
  logic        powerdown_q;
  logic        brownout_low;
  logic        wd_reset;
  logic        wd_wake;
  logic        any_source;
  logic        supply_hold;
  logic [`EV_W-1:0] event_pulse;

  // Brownout only counts while enabled; watchdog splits by sleep state
  assign brownout_low = BROWNOUT_DETECT_ENABLE && !ABOVE_BROWNOUT_THRESHOLD;
  assign supply_hold  = por_active_q || brownout_low;
  assign wd_reset     = WATCHDOG_EXPIRE && !sleep_q;
  assign wd_wake      = WATCHDOG_EXPIRE && sleep_q && state_q == rst_seq_pkg::ST_RUN;
  assign any_source   = supply_hold || pin_low_q || wd_reset;

  // Hold, then the power-up delay for supply causes, then run
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q     <= rst_seq_pkg::ST_HOLD;
      delay_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        rst_seq_pkg::ST_HOLD:
          if (!any_source)
          begin
            delay_cnt_q <= 32'h0000_0000;
            if ((cause_q == rst_seq_pkg::CAUSE_POWER_ON ||
                 cause_q == rst_seq_pkg::CAUSE_BROWNOUT) && !POWER_UP_DELAY_DISABLE)
              state_q <= rst_seq_pkg::ST_DELAY;
            else
              state_q <= rst_seq_pkg::ST_RUN;
          end
        rst_seq_pkg::ST_DELAY:
          if (any_source)
            state_q <= rst_seq_pkg::ST_HOLD;
          else if (delay_cnt_q == 32'(PUD_CYCLES - 1))
            state_q <= rst_seq_pkg::ST_RUN;
          else
            delay_cnt_q <= delay_cnt_q + 32'h0000_0001;
        rst_seq_pkg::ST_RUN:
          if (any_source)
            state_q <= rst_seq_pkg::ST_HOLD;
        default:
          state_q <= rst_seq_pkg::ST_HOLD;
      endcase
    end
  end

  // Cause capture; priority power-on, brownout, watchdog, pin
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cause_q     <= rst_seq_pkg::CAUSE_POWER_ON;
      timeout_q   <= 1'b1;
      powerdown_q <= 1'b1;
    end
    else if (state_q != rst_seq_pkg::ST_HOLD || any_source)
    begin
      if (por_active_q)
      begin
        cause_q <= rst_seq_pkg::CAUSE_POWER_ON;
        timeout_q <= 1'b1;
        powerdown_q <= 1'b1;
      end
      else if (brownout_low && state_q != rst_seq_pkg::ST_HOLD)
      begin
        cause_q <= rst_seq_pkg::CAUSE_BROWNOUT;
        timeout_q <= 1'b1;
        powerdown_q <= 1'b1;
      end
      else if (wd_reset && state_q == rst_seq_pkg::ST_RUN)
      begin
        cause_q <= rst_seq_pkg::CAUSE_WD_RUN;
        timeout_q <= 1'b0;
        powerdown_q <= 1'b1;
      end
      else if (wd_wake)
      begin
        cause_q <= rst_seq_pkg::CAUSE_WD_SLEEP;
        timeout_q <= 1'b0;
        powerdown_q <= 1'b0;
      end
      else if (pin_low_q && state_q == rst_seq_pkg::ST_RUN)
      begin
        cause_q <= sleep_q ? rst_seq_pkg::CAUSE_PIN_SLEEP : rst_seq_pkg::CAUSE_PIN_RUN;
        powerdown_q <= !sleep_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to core and pin

  // Core reset and register reset; retained registers see neither pulse
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      CORE_RESET_B <= 1'b0;
      REG_RESET_B  <= 1'b0;
      WAKE_UP      <= 1'b0;
    end
    else
    begin
      CORE_RESET_B <= state_q == rst_seq_pkg::ST_RUN && !any_source;
      REG_RESET_B  <= state_q == rst_seq_pkg::ST_RUN && !any_source;
      WAKE_UP      <= wd_wake;
    end
  end

  // Shared pin is input only; watchdog never drives it low
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SHARED_PIN_OUT       <= 1'b1;
      SHARED_PIN_OE        <= 1'b0;
      SHARED_PIN_PULLUP_EN <= 1'b0;
      GENERAL_INPUT_VALUE  <= 1'b0;
    end
    else
    begin
      SHARED_PIN_OUT       <= 1'b1;
      SHARED_PIN_OE        <= 1'b0;
      SHARED_PIN_PULLUP_EN <= EXTERNAL_CLEAR_PIN_ENABLE;
      GENERAL_INPUT_VALUE  <= !EXTERNAL_CLEAR_PIN_ENABLE && SHARED_INPUT_PIN_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt

  logic [1:0]       ctrl_q;
  logic [`EV_W-1:0] irq_status_q;
  logic [`EV_W-1:0] irq_mask_q;
  logic             wr_en;
  logic             rd_en;
  logic             status_rd;

  assign wr_en     = PSEL && PENABLE && PWRITE;
  assign rd_en     = PSEL && PENABLE && !PWRITE;
  assign status_rd = rd_en && PADDR == `OFF_IRQ_STATUS;
  assign event_pulse[`EV_WATCHDOG_WAKE] = wd_wake;
  assign event_pulse[`EV_CLEAR_PIN]     = pin_low_q && state_q == rst_seq_pkg::ST_RUN;
  assign event_pulse[`EV_BROWNOUT]      = brownout_low && state_q == rst_seq_pkg::ST_RUN;

  // Sleep flag is set by software and cleared by any wake or reset
  assign sleep_q = ctrl_q[`CTRL_SLEEP];

  // Control and mask writes; while the chip is held the mask resets and only the control sleep bit clears
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_q     <= `CTRL_RESET;
      irq_mask_q <= `MASK_RESET;
    end
    else
    begin
      if (wr_en && PADDR == `OFF_CTRL)
        ctrl_q <= PWDATA[1:0];
      else if (wd_wake || state_q != rst_seq_pkg::ST_RUN)
        ctrl_q[`CTRL_SLEEP] <= 1'b0;
      if (wr_en && PADDR == `OFF_IRQ_MASK)
        irq_mask_q <= PWDATA[`EV_W-1:0];
      else if (state_q != rst_seq_pkg::ST_RUN)
        irq_mask_q <= `MASK_RESET;
    end
  end

  // Sticky status; a read clears only the bits it reported, so an event that lands
  // between the setup snapshot and the access edge is not lost
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      irq_status_q <= '0;
    else if (status_rd)
      irq_status_q <= (irq_status_q & ~PRDATA[`EV_W-1:0]) | event_pulse;
    else
      irq_status_q <= irq_status_q | event_pulse;
  end

  // Read data, zero-wait answer, error on unmapped address
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ     <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      IRQ     <= |(irq_status_q & irq_mask_q);
      if (PSEL && !PENABLE)
      begin
        case (PADDR)
          `OFF_CAUSE:      PRDATA <= {25'h0, cause_q, 2'h0, powerdown_q, timeout_q};
          `OFF_CTRL:       PRDATA <= {30'h0, ctrl_q};
          `OFF_IRQ_STATUS: PRDATA <= {29'h0, irq_status_q};
          `OFF_IRQ_MASK:   PRDATA <= {29'h0, irq_mask_q};
          `OFF_CALIB:      PRDATA <= CALIB_VALUE;
          default:         PSLVERR <= 1'b1;
        endcase
      end
    end
  end

endmodule

// File: inc/rst_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the reset sequencer.
// Included by the design; definitions only.
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

// Register byte offsets on APB
`define OFF_CAUSE        12'h000
`define OFF_CTRL         12'h004
`define OFF_IRQ_STATUS   12'h008
`define OFF_IRQ_MASK     12'h00C
`define OFF_CALIB        12'h010

// Cause register fields
`define CAUSE_TIMEOUT    0
`define CAUSE_POWERDOWN  1
`define CAUSE_CODE_LSB   4
`define CAUSE_CODE_W     3

// Control register fields
`define CTRL_SLEEP       0
`define CTRL_WD_ENABLE   1

// Event bits of the interrupt status
`define EV_WATCHDOG_WAKE 0
`define EV_CLEAR_PIN     1
`define EV_BROWNOUT      2
`define EV_W             3

// Reset values and calibration word address
`define CTRL_RESET       2'h0
`define MASK_RESET       3'h0
`define CALIB_WORD_ADDR  14'h2009

// Timing: clock 100 MHz, times in their own units
`define CLK_HZ           100000000
`define PUD_TIME_MS      64
`define POR_REARM_US     100
`define PUD_CYCLES       (`CLK_HZ / 1000 * `PUD_TIME_MS)
`define REARM_CYCLES     ((`CLK_HZ / 1000000 * `POR_REARM_US))
`define SLOW_OSC_HZ      31000
`define FILTER_CYCLES    16

`endif

// File: inc/rst_seq_pkg.sv
// Types of the reset sequencer.
// Needs nothing from its surroundings.
package rst_seq_pkg;

  // Recorded reset cause
  typedef enum logic [2:0]
  {
    CAUSE_NONE,
    CAUSE_POWER_ON,
    CAUSE_WD_RUN,
    CAUSE_WD_SLEEP,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_BROWNOUT
  } cause_type;

  // Sequencer states
  typedef enum logic [1:0]
  {
    ST_HOLD,
    ST_DELAY,
    ST_RUN
  } seq_state_type;

endpackage

// File: tb/rst_seq_properties.sv
// Checker of the reset sequencer: reset sources, shared pin and APB answer.
// Bound into reset_and_powerup_control; sees only that module's ports.
`timescale 1ns/1ps
module rst_seq_properties
#(
  parameter int FILTER_CYCLES = 16
)
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic SUPPLY_AT_GROUND,
  input wire logic ABOVE_BROWNOUT_THRESHOLD,
  input wire logic BROWNOUT_DETECT_ENABLE,
  input wire logic EXTERNAL_CLEAR_PIN_ENABLE,
  input wire logic SHARED_INPUT_PIN_IN,
  input wire logic WATCHDOG_EXPIRE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CORE_RESET_B,
  input wire logic REG_RESET_B,
  input wire logic WAKE_UP,
  input wire logic SHARED_PIN_PULLUP_EN,
  input wire logic SHARED_PIN_OUT,
  input wire logic SHARED_PIN_OE,
  input wire logic GENERAL_INPUT_VALUE
);
  ////////////////////////////////////////
  logic [7:0] low_q;

  // Length of the present low on an enabled clear pin; saturates so it never wraps
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      low_q <= 8'h00;
    else if (!EXTERNAL_CLEAR_PIN_ENABLE || SHARED_INPUT_PIN_IN)
      low_q <= 8'h00;
    else if (low_q != 8'hFF)
      low_q <= low_q + 8'h01;
  end

  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  // Running, no source active, pin lows far shorter than the filter
  sequence calm_s;
    CORE_RESET_B && !WATCHDOG_EXPIRE && !SUPPLY_AT_GROUND && low_q < 8'h08 &&
    (!BROWNOUT_DETECT_ENABLE || ABOVE_BROWNOUT_THRESHOLD);
  endsequence
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence

  ////////////////////////////////////////
  AST_PIN_NOT_DRIVEN: assert property (!SHARED_PIN_OE && SHARED_PIN_OUT)
    else $error("shared pin driven");
  AST_PULLUP: assert property ($stable(EXTERNAL_CLEAR_PIN_ENABLE) |=>
    SHARED_PIN_PULLUP_EN == $past(EXTERNAL_CLEAR_PIN_ENABLE))
    else $error("pull-up does not follow enable");
  AST_GPIN_OFF: assert property (EXTERNAL_CLEAR_PIN_ENABLE[*3] |-> !GENERAL_INPUT_VALUE)
    else $error("general input live in reset mode");
  AST_GPIN_ON: assert property ((!EXTERNAL_CLEAR_PIN_ENABLE && SHARED_INPUT_PIN_IN)[*5]
    |-> GENERAL_INPUT_VALUE)
    else $error("general input lost");
  AST_SHORT_LOW: assert property (calm_s[*6] |=> CORE_RESET_B)
    else $error("reset without a valid source");
  AST_LONG_LOW: assert property (low_q == FILTER_CYCLES + 6 |-> !CORE_RESET_B)
    else $error("long pin low gave no reset");
  AST_BROWNOUT: assert property ((BROWNOUT_DETECT_ENABLE && !ABOVE_BROWNOUT_THRESHOLD)[*6]
    |-> !CORE_RESET_B && !REG_RESET_B)
    else $error("brownout not held in reset");
  AST_REG_WITH_CORE: assert property (!REG_RESET_B |-> !CORE_RESET_B)
    else $error("register reset alone");
  AST_WAKE: assert property (WAKE_UP |-> CORE_RESET_B && REG_RESET_B ##1 !WAKE_UP)
    else $error("wake is not a clean pulse");
  AST_APB_READY: assert property (setup_s ##1 PENABLE |-> PREADY)
    else $error("no answer in access phase");
  AST_APB_ERR: assert property (PSLVERR |-> PREADY)
    else $error("error outside answer");
endmodule

bind reset_and_powerup_control rst_seq_properties
  #(.FILTER_CYCLES(FILTER_CYCLES)) i_rst_seq_properties (.*);

// File: tb/rst_env_model.sv
// Far side of the sequencer: supply monitors and clear pin network.
// Levels come from the bench; the pin level is resolved from every driver.
`timescale 1ns/1ps
module rst_env_model
(
  input  wire logic clk,
  input  wire logic pwr_on,
  input  wire logic at_gnd,
  input  wire logic bo_ok,
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic pullup_en,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output logic      supply_good,
  output logic      supply_at_ground,
  output logic      above_thr,
  output logic      pin
);
  ////////////////////////////////////////
  logic toggle_q = 1'b0;

  // Floating pin wanders so a stale level is never read as valid
  always_ff @(posedge clk)
    toggle_q <= !toggle_q;

  // Wire level from the device driver, the board driver, then the pull-up
  always_comb
  begin
    if (pin_oe)
      pin = pin_out;
    else if (drv_en)
      pin = drv_val;
    else if (pullup_en)
      pin = 1'b1;
    else
      pin = toggle_q;
  end

  // Monitors: supply is only good when it is not at ground
  assign supply_good      = pwr_on && !at_gnd;
  assign supply_at_ground = at_gnd;
  assign above_thr        = bo_ok;
endmodule

// File: tb/reset_and_powerup_control_tb.sv
// Self-checking bench of the reset sequencer with an APB master.
// Far side from rst_env_model; reads checked against a queue of notes.
`timescale 1ns/1ps
module reset_and_powerup_control_tb;
  localparam int PUD = 50;
  localparam logic [31:0] CAL = 32'hC0DE_5A01;  // Arbitrary trim value
  logic clk = 1'b0, rst_b = 1'b0, pwr = 1'b0, gnd = 1'b0, bo = 1'b1, bde = 1'b0;
  logic en = 1'b1, pud_dis = 1'b0, drv_en = 1'b0, drv_val = 1'b1, wd = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  logic rdy, err, core, regr, wake, pu, pout, poe, giv, irq, sg, sag, abt, pin;
  logic [32:0] exp_q[$];
  int n_fail = 0, check_count = 0, n, seen, r, seed = 1;

  ////////////////////////////////////////
  reset_and_powerup_control #(.PUD_CYCLES(PUD), .REARM_CYCLES(20), .CALIB_VALUE(CAL))
    i_reset_and_powerup_control (.CLK_SYS(clk), .RST_B(rst_b), .SUPPLY_GOOD(sg),
    .SUPPLY_AT_GROUND(sag), .ABOVE_BROWNOUT_THRESHOLD(abt), .BROWNOUT_DETECT_ENABLE(bde),
    .EXTERNAL_CLEAR_PIN_ENABLE(en), .POWER_UP_DELAY_DISABLE(pud_dis),
    .SHARED_INPUT_PIN_IN(pin), .WATCHDOG_EXPIRE(wd), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(rdata), .PREADY(rdy),
    .PSLVERR(err), .CORE_RESET_B(core), .REG_RESET_B(regr), .WAKE_UP(wake),
    .SHARED_PIN_PULLUP_EN(pu), .SHARED_PIN_OUT(pout), .SHARED_PIN_OE(poe),
    .GENERAL_INPUT_VALUE(giv), .IRQ(irq));
  rst_env_model i_rst_env_model (.clk(clk), .pwr_on(pwr), .at_gnd(gnd), .bo_ok(bo),
    .drv_en(drv_en), .drv_val(drv_val), .pullup_en(pu), .pin_oe(poe), .pin_out(pout),
    .supply_good(sg), .supply_at_ground(sag), .above_thr(abt), .pin(pin));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = !clk;
  end

  ////////////////////////////////////////
  task bad(input string m);
    $display("BAD %0t %s", $time, m);
    n_fail++;
  endtask
  task chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) bad(m);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; a read notes its data, error set above the last register
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    if (!w) exp_q.push_back({a > 12'h010, d});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (k == 20) bad("no ready");
    if (k == 20) end_of_test();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Cycles until the chip reset reaches level v
  task automatic wait_core(input logic v, output int c);
    c = 0;
    while (core !== v && c < 5000)
    begin
      @(posedge clk);
      c++;
    end
    if (c == 5000) bad("reset hang");
    if (c == 5000) end_of_test();
  endtask

  // Read answers compared in order with the notes
  always @(posedge clk)
  begin
    if (psel && pen && rdy === 1'b1 && !pwrite)
    begin
      check_count++;
      if ({err, rdata} !== exp_q.pop_front()) bad("read data");
    end
  end

  ////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    chk(core === 1'b0 && regr === 1'b0, "no supply");
    pwr <= 1'b1;
    wait_core(1'b1, n);
    chk(n >= PUD && n <= PUD + 6, "power-up delay");
    apb(1'b0, 12'h000, 32'h13);
    apb(1'b0, 12'h010, CAL);
    apb(1'b0, 12'h020, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    wd <= 1'b1;
    seen = 0;
    repeat (6)
    begin
      @(posedge clk);
      wd <= 1'b0;
      if (wake === 1'b1) seen++;
    end
    chk(seen == 1 && core === 1'b1, "wake");
    apb(1'b0, 12'h000, 32'h30);
    apb(1'b0, 12'h004, 32'h0);
    chk(irq === 1'b0, "masked irq");
    apb(1'b1, 12'h00C, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq === 1'b1, "irq");
    apb(1'b0, 12'h008, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "irq clear");
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    wait_core(1'b0, n);
    chk(pin === 1'b1, "pin pulled");
    wait_core(1'b1, n);
    chk(n < PUD, "no delay");
    apb(1'b0, 12'h000, 32'h22);
    apb(1'b0, 12'h00C, 32'h0);
    drv_val <= 1'b0;
    drv_en <= 1'b1;
    repeat (8) @(posedge clk);
    drv_en <= 1'b0;
    repeat (10) @(posedge clk);
    chk(core === 1'b1, "short pulse");
    drv_en <= 1'b1;
    wait_core(1'b0, n);
    chk(n >= 16, "filter");
    repeat (6) @(posedge clk);
    drv_en <= 1'b0;
    wait_core(1'b1, n);
    apb(1'b0, 12'h000, 32'h42);
    // Same long low while asleep: recorded as the sleeping pin cause
    apb(1'b1, 12'h004, 32'h1);
    drv_en <= 1'b1;
    wait_core(1'b0, n);
    drv_en <= 1'b0;
    wait_core(1'b1, n);
    apb(1'b0, 12'h000, 32'h50);
    for (r = 0; r < 2; r++)
    begin
      bde <= 1'b1;
      pud_dis <= r[0];
      bo <= 1'b0;
      wait_core(1'b0, n);
      repeat (6) @(posedge clk);
      bo <= 1'b1;
      wait_core(1'b1, n);
      chk((n >= PUD) == (r == 0), "brownout delay");
      apb(1'b0, 12'h000, 32'h63);
    end
    bde <= 1'b0;
    pwr <= 1'b0;
    repeat (20) @(posedge clk);
    chk(core === 1'b1, "falling supply");
    // Supply parked at ground long enough re-arms the detector; the next rise resets
    gnd <= 1'b1;
    repeat (25) @(posedge clk);
    gnd <= 1'b0;
    pwr <= 1'b1;
    wait_core(1'b0, n);
    wait_core(1'b1, n);
    apb(1'b0, 12'h000, 32'h13);
    drv_val <= 1'b1;
    drv_en <= 1'b1;
    en <= 1'b0;
    repeat (8)
    begin
      r = $random(seed);
      drv_val <= r[0];
      repeat (5) @(posedge clk);
      chk(giv === drv_val && core === 1'b1, "general input");
    end
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
